// file: design/bsms_sequencer.sv
// startup and mode sequencer of a fixed-output boost regulator
// Operation
// - enable and no lockout start first precharge
// - first precharge exits to soft start
// - first precharge times out into second
// - second precharge uses higher source current
// - second precharge timeout faults, restart later
// - soft start switches at half limit
// - soft start overload too long faults
// - large capacitance slows reference ramp steps
// - input above target enters pass-through
// - enable low after startup forces pass-through
// - boost current limit for 2 ms faults
// - fault stops switching, path off, retries
// - pass-through after quiet time, linear first
`timescale 1ns/1ps
module bsms_sequencer
  import bsms_pkg::*;
#(
  parameter logic [15:0] PRE1_TIMEOUT = PRE1_TICKS,
  parameter logic [15:0] PRE2_TIMEOUT = PRE2_TICKS,
  parameter logic [15:0] SOFT_OVL     = SOFT_OVL_TICKS,
  parameter logic [15:0] BOOST_CL     = BOOST_CL_TICKS,
  parameter logic [15:0] RESTART      = RESTART_TICKS
)
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // enable pin and supply monitor
  input  wire logic  enable_pin,
  input  wire logic  supply_low_lockout,
  // analog comparator flags
  input  wire logic  out_near_in,
  input  wire logic  out_at_target,
  input  wire logic  in_above_target,
  input  wire logic  in_above_out,
  input  wire logic  in_out_drop_high,
  input  wire logic  soft_overload,
  input  wire logic  boost_current_limit,
  input  wire logic  large_cap,
  // power stage controls
  output logic       source_en,
  output logic       source_high,
  output logic       bypass_linear,
  output logic       bypass_full,
  output logic       switch_en,
  output logic       limit_half,
  // reference ramp
  output logic       ref_step,
  output logic [7:0] ref_level,
  // status
  output bsms_state_t mode_state,
  output logic       fault_active,
  output logic       startup_done
);

  logic              us_tick;
  logic [SYNC_N-1:0] raw_in;
  logic [SYNC_N-1:0] clean_in;
  logic              en_s;
  logic              lock_s;
  logic              near_s;
  logic              tgt_s;
  logic              in_hi_s;
  logic              in_out_s;
  logic              drop_s;
  logic              ovl_s;
  logic              cl_s;
  logic              cap_s;

  bsms_state_t       state;
  bsms_state_t       next_state;
  logic [15:0]       state_us;
  logic [15:0]       next_state_us;
  logic [15:0]       ovl_us;
  logic [15:0]       next_ovl_us;
  logic [15:0]       cl_us;
  logic [15:0]       next_cl_us;
  logic [15:0]       quiet_us;
  logic [15:0]       next_quiet_us;
  logic [3:0]        ramp_div;
  logic [3:0]        next_ramp_div;
  logic [7:0]        next_ref_level;
  logic              next_ref_step;
  logic              next_started;
  logic              next_switch_en;
  logic              pt_request;
  logic              pt_ready;
  logic              ramp_due;
  logic              changing;

  // microsecond timebase shared by all timers
  bsms_timebase u_timebase (
    .clk     (clk),
    .rstn    (rstn),
    .us_tick (us_tick)
  );

  // bring pin and comparator levels into the clock domain
  assign raw_in = {large_cap, boost_current_limit, soft_overload, in_out_drop_high,
                   in_above_out, in_above_target, out_at_target, out_near_in,
                   enable_pin};

  bsms_sync u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in (raw_in),
    .sync_out (clean_in)
  );

  assign {cap_s, cl_s, ovl_s, drop_s, in_out_s, in_hi_s, tgt_s, near_s, en_s} = clean_in;

  // lockout is active high from the supply monitor; synchronise it apart from the rest, reset to locked
  logic lock_q1;
  logic lock_q2;
  logic lock_q3;
  logic next_lock;

  always_comb begin
    next_lock = (lock_q2 == lock_q3) ? lock_q2 : lock_s;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_q1 <= 1'b1;
      lock_q2 <= 1'b1;
      lock_q3 <= 1'b1;
      lock_s  <= 1'b1;
    end else begin
      lock_q1 <= supply_low_lockout;
      lock_q2 <= lock_q1;
      lock_q3 <= lock_q2;
      lock_s  <= next_lock;
    end
  end

  // pass-through request and its readiness after the switching quiet time
  // interval compares other than soft overload (>= on a tick) are strict: the first tick lands at an unknown phase,
  // so one extra tick makes every interval at least its full length
  always_comb begin
    pt_request = in_hi_s | (startup_done & !en_s);
    pt_ready   = (quiet_us > PT_QUIET_TICKS) &
                 (in_out_s | (startup_done & !en_s));
  end

  // mode transitions
  always_comb begin
    next_state = state;
    unique case (state)
      BSMS_IDLE: begin
        if (en_s && !lock_s) begin
          next_state = BSMS_PRE_FIRST;
        end
      end
      BSMS_PRE_FIRST: begin
        if (lock_s) begin
          next_state = BSMS_FAULT;
        end else if (near_s) begin
          next_state = BSMS_SOFT_START;
        end else if (state_us > PRE1_TIMEOUT) begin
          next_state = BSMS_PRE_SECOND;
        end
      end
      BSMS_PRE_SECOND: begin
        if (lock_s) begin
          next_state = BSMS_FAULT;
        end else if (near_s) begin
          next_state = BSMS_SOFT_START;
        end else if (state_us > PRE2_TIMEOUT) begin
          next_state = BSMS_FAULT;
        end
      end
      BSMS_SOFT_START: begin
        if (lock_s) begin
          next_state = BSMS_FAULT;
        end else if (us_tick && ovl_s && ovl_us >= SOFT_OVL) begin
          next_state = BSMS_FAULT;
        end else if (pt_request && pt_ready) begin
          next_state = BSMS_PASS;
        end else if (tgt_s && !pt_request) begin
          next_state = BSMS_BOOST;
        end
      end
      BSMS_BOOST: begin
        if (lock_s) begin
          next_state = BSMS_FAULT;
        end else if (cl_us > BOOST_CL) begin
          next_state = BSMS_FAULT;
        end else if (pt_request && pt_ready) begin
          next_state = BSMS_PASS;
        end
      end
      BSMS_PASS: begin
        if (lock_s || (startup_done && drop_s)) begin
          next_state = BSMS_FAULT;
        end else if (!pt_request) begin
          next_state = BSMS_BOOST;
        end
      end
      BSMS_FAULT: begin
        if (state_us > RESTART) begin
          next_state = BSMS_IDLE;
        end
      end
      default: begin
        next_state = BSMS_FAULT;
      end
    endcase
    changing = (next_state != state);
  end

  // microsecond counters, each cleared by any transition
  always_comb begin
    next_state_us = state_us;
    next_ovl_us   = ovl_us;
    next_cl_us    = cl_us;
    next_quiet_us = quiet_us;
    if (changing) begin
      next_state_us = CNT_ZERO;
      next_ovl_us   = CNT_ZERO;
      next_cl_us    = CNT_ZERO;
      next_quiet_us = CNT_ZERO;
    end else if (us_tick) begin
      if (state_us != CNT_MAX) begin
        next_state_us = state_us + CNT_ONE;
      end
      next_ovl_us   = (ovl_s && ovl_us != CNT_MAX) ? ovl_us + CNT_ONE : CNT_ZERO;
      next_cl_us    = (cl_s && state == BSMS_BOOST && cl_us != CNT_MAX) ?
                      cl_us + CNT_ONE : CNT_ZERO;
      next_quiet_us = (!switch_en && quiet_us != CNT_MAX) ? quiet_us + CNT_ONE : CNT_ZERO;
    end
    if (!ovl_s) begin
      next_ovl_us = CNT_ZERO;
    end
    if (!cl_s) begin
      next_cl_us = CNT_ZERO;
    end
    if (switch_en) begin
      next_quiet_us = CNT_ZERO;
    end
  end

  // soft-start reference ramp, slower with a large output capacitor
  always_comb begin
    ramp_due       = cap_s ? (ramp_div >= RAMP_SLOW_LAST) : 1'b1;
    next_ramp_div  = ramp_div;
    next_ref_level = ref_level;
    next_ref_step  = 1'b0;
    if (next_state != BSMS_SOFT_START) begin
      next_ramp_div  = RAMP_DIV_ZERO;
      next_ref_level = (next_state == BSMS_BOOST || next_state == BSMS_PASS) ?
                       REF_MAX : REF_ZERO;
    end else if (us_tick && ref_level != REF_MAX) begin
      if (ramp_due) begin
        next_ramp_div  = RAMP_DIV_ZERO;
        next_ref_level = ref_level + REF_ONE;
        next_ref_step  = 1'b1;
      end else begin
        next_ramp_div  = ramp_div + RAMP_DIV_ONE;
      end
    end
  end

  // startup completion and switching request
  always_comb begin
    next_started = startup_done;
    if (next_state == BSMS_BOOST) begin
      next_started = 1'b1;
    end else if (next_state == BSMS_FAULT || next_state == BSMS_IDLE) begin
      next_started = 1'b0;
    end
    next_switch_en = 1'b0;
    if (next_state == BSMS_SOFT_START || next_state == BSMS_BOOST) begin
      next_switch_en = !pt_request;
    end
  end

  // register sequencer state and power stage controls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state         <= BSMS_IDLE;
      state_us      <= CNT_ZERO;
      ovl_us        <= CNT_ZERO;
      cl_us         <= CNT_ZERO;
      quiet_us      <= CNT_ZERO;
      ramp_div      <= RAMP_DIV_ZERO;
      ref_level     <= REF_ZERO;
      ref_step      <= 1'b0;
      startup_done  <= 1'b0;
      switch_en     <= 1'b0;
      limit_half    <= 1'b0;
      source_en     <= 1'b0;
      source_high   <= 1'b0;
      bypass_linear <= 1'b0;
      bypass_full   <= 1'b0;
      fault_active  <= 1'b0;
      mode_state    <= BSMS_IDLE;
    end else begin
      state         <= next_state;
      state_us      <= next_state_us;
      ovl_us        <= next_ovl_us;
      cl_us         <= next_cl_us;
      quiet_us      <= next_quiet_us;
      ramp_div      <= next_ramp_div;
      ref_level     <= next_ref_level;
      ref_step      <= next_ref_step;
      startup_done  <= next_started;
      switch_en     <= next_switch_en;
      limit_half    <= (next_state == BSMS_SOFT_START);
      source_en     <= (next_state == BSMS_PRE_FIRST) ||
                       (next_state == BSMS_PRE_SECOND);
      source_high   <= (next_state == BSMS_PRE_SECOND);
      bypass_linear <= (next_state == BSMS_PASS) &&
                       (next_state_us <= PT_LINEAR_TICKS);
      bypass_full   <= (next_state == BSMS_PASS) &&
                       (next_state_us > PT_LINEAR_TICKS);
      fault_active  <= (next_state == BSMS_FAULT);
      mode_state    <= next_state;
    end
  end

endmodule

// file: design/bsms_sync.sv
// three-stage synchroniser with agreement filter per input bit
`timescale 1ns/1ps
module bsms_sync
  import bsms_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // asynchronous inputs and their clean copies
  input  wire logic [SYNC_N-1:0] async_in,
  output logic      [SYNC_N-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < SYNC_N; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic next_out;

      // accept a change only when the last two stages agree
      always_comb begin
        next_out = (s2 == s3) ? s2 : sync_out[i];
      end

      // register the chain
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          s1          <= 1'b0;
          s2          <= 1'b0;
          s3          <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1          <= async_in[i];
          s2          <= s1;
          s3          <= s2;
          sync_out[i] <= next_out;
        end
      end
    end
  endgenerate

endmodule

// file: design/bsms_timebase.sv
// free-running one-microsecond tick divider
`timescale 1ns/1ps
module bsms_timebase
  import bsms_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // one-cycle pulse every microsecond
  output logic      us_tick
);

  logic [7:0] div;
  logic [7:0] next_div;
  logic       next_tick;

  // count clock cycles up to one pulse per microsecond
  always_comb begin
    next_tick = (div == TB_LAST);
    next_div  = next_tick ? TB_ZERO : div + 8'h01;
  end

  // register divider state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div     <= TB_ZERO;
      us_tick <= 1'b0;
    end else begin
      div     <= next_div;
      us_tick <= next_tick;
    end
  end

endmodule

// file: pkg/bsms_pkg.sv
// shared constants and state encoding of the boost startup mode sequencer
package bsms_pkg;

  // clock and microsecond timebase
  localparam int          CLK_FREQ_HZ  = 200_000_000;
  localparam int          HZ_PER_MHZ   = 1_000_000;
  localparam int          US_CYCLES    = CLK_FREQ_HZ / HZ_PER_MHZ;
  localparam int          TB_W         = 8;
  localparam logic [7:0]  TB_LAST      = 8'(US_CYCLES - 1);
  localparam logic [7:0]  TB_ZERO      = 8'h00;

  // times in their own units
  localparam int          US_PER_MS        = 1000;
  localparam int          PRE1_TIMEOUT_US  = 512;
  localparam int          PRE2_TIMEOUT_US  = 1024;
  localparam int          SOFT_OVL_US      = 64;
  localparam int          BOOST_CL_MS      = 2;
  localparam int          RESTART_MS       = 20;
  localparam int          PT_QUIET_US      = 5;
  localparam int          PT_LINEAR_US     = 5;

  // times as microsecond tick counts
  localparam int          CNT_W            = 16;
  localparam logic [15:0] CNT_ZERO         = 16'h0000;
  localparam logic [15:0] CNT_ONE          = 16'h0001;
  localparam logic [15:0] CNT_MAX          = 16'hffff;
  localparam logic [15:0] PRE1_TICKS       = 16'(PRE1_TIMEOUT_US);
  localparam logic [15:0] PRE2_TICKS       = 16'(PRE2_TIMEOUT_US);
  localparam logic [15:0] SOFT_OVL_TICKS   = 16'(SOFT_OVL_US);
  localparam logic [15:0] BOOST_CL_TICKS   = 16'(BOOST_CL_MS * US_PER_MS);
  localparam logic [15:0] RESTART_TICKS    = 16'(RESTART_MS * US_PER_MS);
  localparam logic [15:0] PT_QUIET_TICKS   = 16'(PT_QUIET_US);
  localparam logic [15:0] PT_LINEAR_TICKS  = 16'(PT_LINEAR_US);

  // soft-start reference ramp
  localparam logic [7:0]  REF_ZERO         = 8'h00;
  localparam logic [7:0]  REF_ONE          = 8'h01;
  localparam logic [7:0]  REF_MAX          = 8'hff;
  localparam logic [3:0]  RAMP_DIV_ZERO    = 4'h0;
  localparam logic [3:0]  RAMP_DIV_ONE     = 4'h1;
  localparam logic [3:0]  RAMP_SLOW_LAST   = 4'h3;

  // synchronised input count
  localparam int          SYNC_N           = 9;

  // operating states, gray codes along the startup path
  typedef enum logic [2:0] {
    BSMS_IDLE       = 3'h0,
    BSMS_PRE_FIRST  = 3'h1,
    BSMS_PRE_SECOND = 3'h3,
    BSMS_SOFT_START = 3'h2,
    BSMS_BOOST      = 3'h6,
    BSMS_PASS       = 3'h7,
    BSMS_FAULT      = 3'h5
  } bsms_state_t;

endpackage

// file: verification/bsms_chk.sv
// port-level assertions for the boost startup mode sequencer
`timescale 1ns/1ps
module bsms_chk
  import bsms_pkg::*;
#(
  parameter logic [15:0] PRE1_TIMEOUT = PRE1_TICKS,
  parameter logic [15:0] PRE2_TIMEOUT = PRE2_TICKS,
  parameter logic [15:0] RESTART      = RESTART_TICKS
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // watched outputs
  input wire bsms_state_t mode_state,
  input wire logic        source_en,
  input wire logic        source_high,
  input wire logic        switch_en,
  input wire logic        limit_half,
  input wire logic        bypass_linear,
  input wire logic        bypass_full,
  input wire logic        fault_active,
  input wire logic        startup_done,
  input wire logic [7:0]  ref_level
);
  localparam int P1LO = int'(PRE1_TIMEOUT) * US_CYCLES - 3;
  localparam int P1HI = (int'(PRE1_TIMEOUT) + 1) * US_CYCLES + 3;
  localparam int P2LO = int'(PRE2_TIMEOUT) * US_CYCLES - 3;
  localparam int P2HI = (int'(PRE2_TIMEOUT) + 1) * US_CYCLES + 3;
  localparam int RSLO = int'(RESTART) * US_CYCLES - 3;
  localparam int RSHI = (int'(RESTART) + 1) * US_CYCLES + 3;
  bsms_state_t prev;
  int          sc;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // cycles spent in the current state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= BSMS_IDLE;
      sc   <= 0;
    end else begin
      prev <= mode_state;
      sc   <= (mode_state != prev) ? 1 : sc + 1;
    end
  end

  property p_pre1;
    mode_state == BSMS_PRE_FIRST |-> source_en && !source_high && !switch_en;
  endproperty
  a_pre1: assert property (p_pre1) else $error("first precharge outputs wrong");
  property p_pre1_to;
    (prev == BSMS_PRE_FIRST && mode_state == BSMS_PRE_SECOND) |-> sc inside {[P1LO:P1HI]};
  endproperty
  a_pre1_to: assert property (p_pre1_to) else $error("first precharge timeout off");
  property p_pre2;
    mode_state == BSMS_PRE_SECOND |-> source_en && source_high;
  endproperty
  a_pre2: assert property (p_pre2) else $error("second precharge current wrong");
  property p_pre2_to;
    (prev == BSMS_PRE_SECOND && mode_state == BSMS_FAULT) |-> sc inside {[P2LO:P2HI]};
  endproperty
  a_pre2_to: assert property (p_pre2_to) else $error("second precharge timeout off");
  property p_soft;
    $rose(mode_state == BSMS_SOFT_START) |-> limit_half && switch_en && !source_en;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start entry outputs wrong");
  property p_boost;
    mode_state == BSMS_BOOST |-> ref_level == 8'hff && !limit_half && startup_done;
  endproperty
  a_boost: assert property (p_boost) else $error("boost outputs wrong");
  property p_flt;
    fault_active |-> !switch_en && !bypass_linear && !bypass_full && !source_en;
  endproperty
  a_flt: assert property (p_flt) else $error("fault state still drives stage");
  property p_flt_to;
    (prev == BSMS_FAULT && mode_state != BSMS_FAULT) |->
      mode_state == BSMS_IDLE && sc inside {[RSLO:RSHI]};
  endproperty
  a_flt_to: assert property (p_flt_to) else $error("restart delay off");
  property p_pass;
    $rose(mode_state == BSMS_PASS) |-> (bypass_linear && !bypass_full && !switch_en) [*8];
  endproperty
  a_pass: assert property (p_pass) else $error("pass entry not linear");
endmodule

// file: verification/bsms_host_model.sv
// host logic driving the enable pin
`timescale 1ns/1ps
module bsms_host_model #(
  parameter int HOLD_CYC = 350 * 200
)
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // request from the bench and the pin
  input  wire logic en_req,
  output logic      enable_pin
);
  int hc;

  // low is only let through once the high time counted since reset reaches the minimum
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_pin <= 1'b0;
      hc         <= 0;
    end else if (en_req) begin
      enable_pin <= 1'b1;
      if (hc < HOLD_CYC) hc <= hc + 1;
    end else if (hc >= HOLD_CYC) begin
      enable_pin <= 1'b0;
    end
  end
endmodule

// file: verification/bsms_tb.sv
// self-checking bench of the boost startup mode sequencer
`timescale 1ns/1ps
module testbench
  import bsms_pkg::*;
;
  localparam int US = US_CYCLES;
  localparam logic [15:0] P1 = 16'h0008, P2 = 16'h0010, OV = 16'h0004;
  localparam logic [15:0] CL = 16'h000a, RS = 16'h0014;
  logic clk = 1'b0, rstn = 1'b0, en_req = 1'b1, lock = 1'b0, near = 1'b0, tgt = 1'b0;
  logic ia_tgt = 1'b0, ia_out = 1'b0, drop = 1'b0, ovl = 1'b0, cl = 1'b0, lcap = 1'b0;
  logic enable_pin, source_en, source_high, bypass_linear, bypass_full, switch_en;
  logic limit_half, ref_step, startup_done, fault_active;
  logic [7:0]  ref_level;
  bsms_state_t mode_state;
  bsms_state_t exp_q[$];
  int err_total = 0, checks = 0, seed = 32'h0395582d, n;

  always #2.5 clk = ~clk;

  bsms_host_model #(.HOLD_CYC(20 * US)) u_host (.clk(clk), .rstn(rstn), .en_req(en_req),
    .enable_pin(enable_pin));
  bsms_sequencer #(.PRE1_TIMEOUT(P1), .PRE2_TIMEOUT(P2), .SOFT_OVL(OV), .BOOST_CL(CL),
    .RESTART(RS)) uut (.clk(clk), .rstn(rstn), .enable_pin(enable_pin),
    .supply_low_lockout(lock), .out_near_in(near), .out_at_target(tgt),
    .in_above_target(ia_tgt), .in_above_out(ia_out), .in_out_drop_high(drop),
    .soft_overload(ovl), .boost_current_limit(cl), .large_cap(lcap), .source_en,
    .source_high, .bypass_linear, .bypass_full, .switch_en, .limit_half, .ref_step,
    .ref_level, .mode_state, .fault_active, .startup_done);

  task automatic summarize();
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // model step: expected next state, reached between lo and hi cycles
  task automatic go(input bsms_state_t s, input int lo, input int hi);
    int t;
    t = 0;
    exp_q.push_back(s);
    while (mode_state !== s && t < hi) begin
      cyc(1);
      t++;
    end
    chk("state", s, mode_state);
    chk("delay_ok", 1, t >= lo);
    if (mode_state !== s) summarize();
  endtask

  task automatic restart();
    go(BSMS_IDLE, RS * US - 5, (RS + 1) * US + 10);
    go(BSMS_PRE_FIRST, 0, 20);
  endtask

  // every state change must be the next one the model predicts
  always @(mode_state) begin
    if (rstn === 1'b1) begin
      if (exp_q.size() > 0) chk("seq", exp_q.pop_front(), mode_state);
      else chk("seq", 8'hff, mode_state);
    end
  end

  // scenario sequence
  initial begin
    lcap = 1'($random(seed));
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    go(BSMS_PRE_FIRST, 0, 50);
    chk("src", 1, source_en & !source_high);
    cyc(US * (1 + ($unsigned($random(seed)) % 4)));
    near = 1'b1;
    go(BSMS_SOFT_START, 0, 20);
    chk("soft", 1, switch_en & limit_half & !source_en);
    n = 0;
    repeat (16 * US) begin
      cyc(1);
      n += (ref_step === 1'b1);
    end
    chk("steps", 1, lcap ? (n >= 3 && n <= 5) : (n >= 15 && n <= 17));
    tgt = 1'b1;
    go(BSMS_BOOST, 0, 20);
    chk("done", 1, startup_done && ref_level === 8'hff);
    ia_tgt = 1'b1;
    ia_out = 1'b1;
    go(BSMS_PASS, 5 * US, 8 * US);
    chk("lin", 1, bypass_linear & !bypass_full & !switch_en);
    cyc(4 * US);
    chk("lin_hold", 1, bypass_linear & !bypass_full);
    cyc(3 * US);
    chk("full", 1, bypass_full & !bypass_linear);
    ia_tgt = 1'b0;
    ia_out = 1'b0;
    go(BSMS_BOOST, 0, 20);
    en_req = 1'b0;
    go(BSMS_PASS, 5 * US, 8 * US);
    en_req = 1'b1;
    go(BSMS_BOOST, 0, 20);
    en_req = 1'b0;
    go(BSMS_PASS, 5 * US, 8 * US);
    drop = 1'b1;
    go(BSMS_FAULT, 0, 20);
    chk("flt_pass", 1, fault_active & !bypass_linear & !bypass_full);
    drop = 1'b0;
    en_req = 1'b1;
    restart();
    go(BSMS_SOFT_START, 0, 20);
    go(BSMS_BOOST, 0, 20);
    cl = 1'b1;
    go(BSMS_FAULT, (CL - 1) * US, (CL + 1) * US + 20);
    chk("flt", 1, fault_active & !switch_en & !bypass_full & !startup_done);
    cl = 1'b0;
    near = 1'b0;
    tgt = 1'b0;
    restart();
    go(BSMS_PRE_SECOND, P1 * US - 5, (P1 + 1) * US + 10);
    chk("hi", 1, source_en & source_high);
    go(BSMS_FAULT, P2 * US - 5, (P2 + 1) * US + 10);
    restart();
    go(BSMS_PRE_SECOND, P1 * US - 5, (P1 + 1) * US + 10);
    cyc(2 * US);
    near = 1'b1;
    go(BSMS_SOFT_START, 0, 20);
    ovl = 1'b1;
    go(BSMS_FAULT, OV * US, (OV + 2) * US);
    lock = 1'b1;
    rstn = 1'b0;
    cyc(6);
    chk("rst", 1, mode_state === BSMS_IDLE && !source_en && !fault_active);
    rstn = 1'b1;
    cyc(40);
    chk("lock", 1, mode_state === BSMS_IDLE);
    summarize();
  end
endmodule

bind bsms_sequencer bsms_chk #(.PRE1_TIMEOUT(PRE1_TIMEOUT), .PRE2_TIMEOUT(PRE2_TIMEOUT),
  .RESTART(RESTART)) u_chk (.clk(clk), .rstn(rstn), .mode_state(mode_state),
  .source_en(source_en), .source_high(source_high), .switch_en(switch_en),
  .limit_half(limit_half), .bypass_linear(bypass_linear), .bypass_full(bypass_full),
  .fault_active(fault_active), .startup_done(startup_done), .ref_level(ref_level));
